/* rtl/fud_pkg.sv */
// Shared constants and types for the FIFO UART core
// ----------------------------------------------------------------------
// How it works
// (RULE1) Serial output idles high from reset until a character goes out.
// (RULE2) With FIFOs on, fifo_control bit 3 picks the DMA signalling mode.
// (RULE3) Without FIFOs only DMA mode 0 is used, whatever bit 3 holds.
// (RULE4) DMA mode 0 requests one transfer at a time.
// (RULE5) DMA mode 1 keeps transmit requests going until the FIFO is full.
// (RULE6) A selected write is taken on either write strobe polarity.
// (RULE7) Host uses one strobe and parks the other inactive.
// (RULE8) Sleep floats the oscillator output, else it is osc_in inverted.
// (RULE9) Characters carry a start bit and stop bits; receiver syncs on them.
// (RULE10) Optional parity bit is sent, checked, and mismatches are flagged.
// (RULE11) A 64-byte transmit FIFO and a 64-byte receive FIFO.
// (RULE12) Four selectable receive trigger levels.
// (RULE13) Twelve host registers behind eight addresses. The core has no modem state register; index 6 reads as zero.
// (RULE14) Divisor 1 gives clock/16 bit rate, 3 Mbit/s from 48 MHz.
// (RULE15) Divisor bytes replace addresses 0 and 1 while line_control bit 7.
// (RULE16) Both FIFOs work as 64 bytes only while fifo_control bit 0 set.
// (RULE17) Receive mode 1 request starts at trigger or time-out, ends empty.
// (RULE18) Bit rate is clock over 16 times the divisor.
// (RULE19) Transmit mode 0 request is active while the transmit side is empty.
// (RULE20) One clock domain; reset returns every register to its reset value. The FIFO storage and its registered read data in fud_fifo_mem are not reset.
// ----------------------------------------------------------------------
`default_nettype none
package fud_pkg;
  // --------------------------------------------------------------------
  // Sizes and timing
  // --------------------------------------------------------------------
  localparam int FUD_FIFO_DEPTH = 64;
  localparam int FUD_OSR = 16;
  localparam logic [3:0] FUD_OS_MID = 4'h7;
  localparam logic [3:0] FUD_OS_LAST = 4'(FUD_OSR - 1);
  localparam int FUD_TMO_CHARS = 4;
  localparam int FUD_CHAR_BITS = 10;
  localparam logic [9:0] FUD_TMO_TICKS =
    10'(FUD_TMO_CHARS * FUD_CHAR_BITS * FUD_OSR);
  // --------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam logic [2:0] FUD_REG_HOLDING = 3'h0;
  localparam logic [2:0] FUD_REG_IRQ_ENABLE = 3'h1;
  localparam logic [2:0] FUD_REG_IRQ_SOURCE = 3'h2;
  localparam logic [2:0] FUD_REG_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] FUD_REG_LINE_CONTROL = 3'h3;
  localparam logic [2:0] FUD_REG_MODEM_CTRL = 3'h4;
  localparam logic [2:0] FUD_REG_LINE_STATE = 3'h5;
  localparam logic [2:0] FUD_REG_MODEM_STATE = 3'h6;
  localparam logic [2:0] FUD_REG_SCRATCH = 3'h7;
  localparam logic [2:0] FUD_REG_DIVISOR_LOW = 3'h0;
  localparam logic [2:0] FUD_REG_DIVISOR_HIGH = 3'h1;
  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int FUD_FC_ENABLE = 0;
  localparam int FUD_FC_RX_RESET = 1;
  localparam int FUD_FC_TX_RESET = 2;
  localparam int FUD_FC_DMA_MODE = 3;
  localparam int FUD_FC_TRIG = 6;
  localparam int FUD_LC_STOP = 2;
  localparam int FUD_LC_PARITY = 3;
  localparam int FUD_LC_EVEN = 4;
  localparam int FUD_LC_BREAK = 6;
  localparam int FUD_LC_DLAB = 7;
  localparam int FUD_IE_RX = 0;
  localparam int FUD_IE_TX = 1;
  localparam int FUD_IE_LINE = 2;
  localparam int FUD_IE_SLEEP = 4;
  localparam int FUD_MC_LOOP = 4;
  // --------------------------------------------------------------------
  // Trigger levels, source codes, reset values
  // --------------------------------------------------------------------
  localparam logic [6:0] FUD_TRIG_0 = 7'h01;
  localparam logic [6:0] FUD_TRIG_1 = 7'h10;
  localparam logic [6:0] FUD_TRIG_2 = 7'h20;
  localparam logic [6:0] FUD_TRIG_3 = 7'h38;
  localparam logic [3:0] FUD_SRC_NONE = 4'h1;
  localparam logic [3:0] FUD_SRC_LINE = 4'h6;
  localparam logic [3:0] FUD_SRC_RX = 4'h4;
  localparam logic [3:0] FUD_SRC_TIMEOUT = 4'hc;
  localparam logic [3:0] FUD_SRC_TX = 4'h2;
  localparam logic [15:0] FUD_DIVISOR_RST = 16'h0001;
  localparam logic [7:0] FUD_LINE_CONTROL_RST = 8'h00;
  typedef enum logic [2:0] {
    PH_IDLE, PH_START, PH_DATA, PH_PARITY, PH_STOP
  } fud_phase_type;
endpackage
`default_nettype wire

/* rtl/fud_fifo_mem.sv */
// Character store for one FIFO, registered read port
`default_nettype none
module fud_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys, // System clock
  input wire logic we, // Write enable
  input wire logic [$clog2(DEPTH)-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [$clog2(DEPTH)-1:0] raddr, // Next head address
  output logic [WIDTH-1:0] rdata // Entry at head, registered
);
  if (WIDTH < 1 || DEPTH < 2) begin : g_chk
    $error("fud_fifo_mem: bad WIDTH or DEPTH");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] q;
  } fud_mem_type;
  fud_mem_type s, n;

  // Write-through so a byte written to an empty FIFO is at once the head
  always_comb begin
    n = s;
    if (we) begin
      n.mem[waddr] = wdata;
    end
    n.q = (we && waddr == raddr) ? wdata : s.mem[raddr];
  end

  // Storage needs no reset; pointers in the core guard stale entries
  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  assign rdata = s.q;
endmodule
`default_nettype wire

/* rtl/fud_uart_core.sv */
// FIFO UART core: Avalon registers, FIFOs, serial engines, DMA requests
`default_nettype none
module fud_uart_core #(
  parameter int DEPTH = fud_pkg::FUD_FIFO_DEPTH // Bytes per FIFO
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [2:0] avs_address, // Register index
  input wire logic avs_chipselect, // Block selected
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic write_strobe_high, // Alternate write, high
  input wire logic write_strobe_low_n, // Alternate write, low
  input wire logic serial_in, // Serial receive pin
  output logic serial_out, // Serial transmit pin
  output logic tx_dma_ready_n, // Transmit DMA request
  output logic rx_dma_ready_n, // Receive DMA request
  input wire logic osc_in, // Oscillator input
  output logic osc_out, // Inverted oscillator
  output logic osc_out_en // High while osc_out driven
);
  import fud_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // Trigger level 56 needs at least 64 entries
  if (DEPTH < 64 || (1 << AW) != DEPTH) begin : g_chk
    $error("fud_uart_core: DEPTH must be a power of two >= 64");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] irq_enable;
    logic [7:0] line_control;
    logic [7:0] modem_ctrl;
    logic [7:0] scratch;
    logic [15:0] divisor;
    logic fen;
    logic dma1;
    logic [1:0] trig;
    logic [AW-1:0] tw;
    logic [AW-1:0] tr;
    logic [AW:0] tc;
    logic [AW-1:0] rw;
    logic [AW-1:0] rr;
    logic [AW:0] rc;
    logic ovr;
    logic tmo;
    logic [9:0] tmo_cnt;
    logic [15:0] bcnt;
    fud_phase_type tph;
    logic [7:0] tsh;
    logic [2:0] tn;
    logic [3:0] tos;
    logic tpar;
    logic tbit;
    logic tout;
    fud_phase_type rph;
    logic [7:0] rsh;
    logic [2:0] rn;
    logic [3:0] ros;
    logic rpar;
    logic rperr;
    logic [2:0] sync;
    logic rlvl;
    logic rxact;
  } fud_state_type;
  fud_state_type s, n;

  logic req, take, rd_take, wr_take, dlab, tick, rbit, rne, pen;
  logic tx_push, tx_pop, rx_push, rx_pop, tx_rst, rx_rst, ovr_set;
  logic [AW:0] limit, trig_lvl;
  logic [AW-1:0] tx_raddr, rx_raddr;
  logic [7:0] txq, rv, line_st;
  logic [9:0] rxq, rx_wdata;
  logic [3:0] src;
  logic [2:0] wl_last;

  // ----------------------------------------------------------------------
  // Character stores
  // ----------------------------------------------------------------------
  fud_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_mem (
    .clk_sys(clk_sys),
    .we(tx_push),
    .waddr(s.tw),
    .wdata(avs_writedata[7:0]),
    .raddr(tx_raddr),
    .rdata(txq)
  );

  // Receive entries carry framing and parity flags above the data
  fud_fifo_mem #(.WIDTH(10), .DEPTH(DEPTH)) u_rx_mem (
    .clk_sys(clk_sys),
    .we(rx_push),
    .waddr(s.rw),
    .wdata(rx_wdata),
    .raddr(rx_raddr),
    .rdata(rxq)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = s;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    tx_rst = 1'b0;
    rx_rst = 1'b0;
    ovr_set = 1'b0;
    rx_wdata = 10'h000;
    rne = s.rc != '0;
    pen = s.line_control[FUD_LC_PARITY];
    wl_last = {1'b1, s.line_control[1:0]};
    dlab = s.line_control[FUD_LC_DLAB];
    // Single-entry depth is the non-FIFO compatibility mode
    limit = s.fen ? FULL_CNT : (AW+1)'(1); // RULE16 RULE11
    case (s.trig) // RULE12
      2'd0: trig_lvl = (AW+1)'(FUD_TRIG_0);
      2'd1: trig_lvl = (AW+1)'(FUD_TRIG_1);
      2'd2: trig_lvl = (AW+1)'(FUD_TRIG_2);
      default: trig_lvl = (AW+1)'(FUD_TRIG_3);
    endcase
    if (!s.fen) begin
      trig_lvl = (AW+1)'(FUD_TRIG_0);
    end
    // Status views; error flags belong to the head character
    line_st = {s.fen & rne & (rxq[8] | rxq[9]),
      s.tc == '0 && s.tph == PH_IDLE, s.tc == '0,
      rne & rxq[9] & (rxq[7:0] == 8'h00), rne & rxq[9],
      rne & rxq[8], s.ovr, rne};
    if (s.irq_enable[FUD_IE_LINE] && (s.ovr || line_st[2] || line_st[3]))
      src = FUD_SRC_LINE;
    else if (s.irq_enable[FUD_IE_RX] && s.tmo)
      src = FUD_SRC_TIMEOUT;
    else if (s.irq_enable[FUD_IE_RX] && rne && s.rc >= trig_lvl)
      src = FUD_SRC_RX; // RULE12
    else if (s.irq_enable[FUD_IE_TX] && s.tc == '0)
      src = FUD_SRC_TX;
    else
      src = FUD_SRC_NONE;

    // Bus: one wait cycle, then the access completes
    req = avs_chipselect & (avs_read | avs_write | write_strobe_high |
      ~write_strobe_low_n); // RULE6
    take = req & s.ack;
    rd_take = take & avs_read;
    wr_take = take & ~avs_read & (avs_byteenable[0] | ~avs_write); // RULE6
    n.ack = req & ~s.ack;
    case (avs_address) // RULE13 RULE15
      FUD_REG_HOLDING: rv = dlab ? s.divisor[7:0] : rxq[7:0];
      FUD_REG_IRQ_ENABLE: rv = dlab ? s.divisor[15:8] : s.irq_enable;
      FUD_REG_IRQ_SOURCE: rv = {s.fen, s.fen, 2'b00, src};
      FUD_REG_LINE_CONTROL: rv = s.line_control;
      FUD_REG_MODEM_CTRL: rv = s.modem_ctrl;
      FUD_REG_LINE_STATE: rv = line_st;
      FUD_REG_SCRATCH: rv = s.scratch;
      default: rv = 8'h00;
    endcase
    if (req && !s.ack) begin
      n.rdata = {24'h000000, rv};
    end
    rx_pop = rd_take && avs_address == FUD_REG_HOLDING && !dlab && rne;
    if (wr_take) begin
      case (avs_address) // RULE13
        FUD_REG_HOLDING: begin
          if (dlab) n.divisor[7:0] = avs_writedata[7:0]; // RULE15
          else tx_push = s.tc < limit;
        end
        FUD_REG_IRQ_ENABLE: begin
          if (dlab) n.divisor[15:8] = avs_writedata[7:0]; // RULE15
          else n.irq_enable = avs_writedata[7:0];
        end
        FUD_REG_FIFO_CONTROL: begin
          n.fen = avs_writedata[FUD_FC_ENABLE]; // RULE16
          n.dma1 = avs_writedata[FUD_FC_DMA_MODE]; // RULE2
          n.trig = avs_writedata[FUD_FC_TRIG +: 2];
          // Switching mode empties both sides
          rx_rst = avs_writedata[FUD_FC_RX_RESET] | (n.fen != s.fen);
          tx_rst = avs_writedata[FUD_FC_TX_RESET] | (n.fen != s.fen);
        end
        FUD_REG_LINE_CONTROL: n.line_control = avs_writedata[7:0];
        FUD_REG_MODEM_CTRL: n.modem_ctrl = avs_writedata[7:0];
        FUD_REG_SCRATCH: n.scratch = avs_writedata[7:0];
        default: ;
      endcase
    end

    // Baud ticks at 16 per bit; divisor 0 behaves as 1
    tick = s.bcnt == 16'h0000; // RULE18 RULE14
    if (tick) n.bcnt = (s.divisor == 16'h0000) ? 16'h0000 : s.divisor - 16'h1;
    else n.bcnt = s.bcnt - 16'h1;

    // Transmit shifter
    case (s.tph) // RULE9 RULE10
      PH_IDLE: begin
        n.tbit = 1'b1;
        if (s.tc != '0 && !tx_rst) begin
          tx_pop = 1'b1;
          n.tsh = txq;
          n.tph = PH_START;
          n.tos = 4'h0;
          n.tbit = 1'b0;
          n.tpar = ~s.line_control[FUD_LC_EVEN];
        end
      end
      default: begin
        if (tick) begin
          n.tos = s.tos + 4'h1;
          if (s.tos == FUD_OS_LAST) begin
            case (s.tph)
              PH_START: begin
                n.tph = PH_DATA;
                n.tn = 3'h0;
                n.tbit = s.tsh[0];
                n.tpar = s.tpar ^ s.tsh[0];
              end
              PH_DATA: begin
                n.tsh = s.tsh >> 1;
                if (s.tn == wl_last) begin
                  n.tn = 3'h0;
                  n.tph = pen ? PH_PARITY : PH_STOP;
                  n.tbit = pen ? s.tpar : 1'b1;
                end else begin
                  n.tn = s.tn + 3'h1;
                  n.tbit = s.tsh[1];
                  n.tpar = s.tpar ^ s.tsh[1];
                end
              end
              PH_PARITY: begin
                n.tph = PH_STOP;
                n.tbit = 1'b1;
              end
              PH_STOP: begin
                if (s.tn == {2'b00, s.line_control[FUD_LC_STOP]})
                  n.tph = PH_IDLE;
                else
                  n.tn = s.tn + 3'h1;
              end
              default: n.tph = PH_IDLE;
            endcase
          end
        end
      end
    endcase
    n.tout = n.tbit & ~n.line_control[FUD_LC_BREAK]; // RULE1

    // Receive line: three stages, a change counts once stages 2 and 3 agree
    n.sync = {s.sync[1:0], serial_in};
    if (s.sync[1] == s.sync[2]) n.rlvl = s.sync[2];
    rbit = s.modem_ctrl[FUD_MC_LOOP] ? s.tout : s.rlvl;
    case (s.rph) // RULE9 RULE10
      PH_IDLE: begin
        if (!rbit) begin
          n.rph = PH_START;
          n.ros = 4'h0;
        end
      end
      default: begin
        if (tick) begin
          n.ros = s.ros + 4'h1;
          case (s.rph)
            PH_START: begin
              if (s.ros == FUD_OS_MID) begin
                // A start bit gone by mid-bit was a glitch
                n.ros = 4'h0;
                n.rph = rbit ? PH_IDLE : PH_DATA;
                n.rn = 3'h0;
                n.rperr = 1'b0;
                n.rpar = ~s.line_control[FUD_LC_EVEN];
              end
            end
            PH_DATA: begin
              if (s.ros == FUD_OS_LAST) begin
                n.rsh = {rbit, s.rsh[7:1]};
                n.rpar = s.rpar ^ rbit;
                if (s.rn == wl_last) n.rph = pen ? PH_PARITY : PH_STOP;
                else n.rn = s.rn + 3'h1;
              end
            end
            PH_PARITY: begin
              if (s.ros == FUD_OS_LAST) begin
                n.rperr = s.rpar ^ rbit;
                n.rph = PH_STOP;
              end
            end
            PH_STOP: begin
              if (s.ros == FUD_OS_LAST) begin
                n.rph = PH_IDLE;
                rx_push = (s.rc < limit) && !rx_rst;
                ovr_set = s.rc >= limit;
                rx_wdata = {~rbit, s.rperr,
                  s.rsh >> (2'd3 - s.line_control[1:0])};
              end
            end
            default: n.rph = PH_IDLE;
          endcase
        end
      end
    endcase

    // Overrun is cleared by reading line_state; a new overrun wins
    n.ovr = (s.ovr & ~(rd_take && avs_address == FUD_REG_LINE_STATE))
      | ovr_set;

    // Four character times of silence with data waiting
    if (!rne || rx_push || rx_pop) begin
      n.tmo_cnt = 10'h000;
      n.tmo = 1'b0;
    end else if (tick && !s.tmo) begin
      n.tmo_cnt = s.tmo_cnt + 10'h001;
      n.tmo = s.tmo_cnt == FUD_TMO_TICKS - 10'h001;
    end

    // FIFO pointers
    if (tx_rst) begin
      n.tw = '0;
      n.tr = '0;
      n.tc = '0;
    end else begin
      n.tw = s.tw + AW'(tx_push);
      n.tr = s.tr + AW'(tx_pop);
      n.tc = s.tc + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
    if (rx_rst) begin
      n.rw = '0;
      n.rr = '0;
      n.rc = '0;
    end else begin
      n.rw = s.rw + AW'(rx_push);
      n.rr = s.rr + AW'(rx_pop);
      n.rc = s.rc + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end

    // Mode 1 receive request latches at trigger or time-out
    n.rxact = s.fen && s.dma1 && n.rc != '0 &&
      (s.rxact || s.rc >= trig_lvl || s.tmo); // RULE17

    if (reset) begin // RULE20
      n = '0;
      n.divisor = FUD_DIVISOR_RST;
      n.line_control = FUD_LINE_CONTROL_RST;
      n.tbit = 1'b1;
      n.tout = 1'b1; // RULE1
      n.sync = 3'h7;
      n.rlvl = 1'b1;
      n.tph = PH_IDLE;
      n.rph = PH_IDLE;
    end
    tx_raddr = n.tr;
    rx_raddr = n.rr;
  end

  // All state in one register
  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = req & ~s.ack;
  assign serial_out = s.tout;
  // Mode 1 only counts while FIFOs are on
  assign tx_dma_ready_n = (s.fen && s.dma1) ? (s.tc == FULL_CNT)
    : (s.tc != '0); // RULE2 RULE3 RULE4 RULE5 RULE19
  assign rx_dma_ready_n = (s.fen && s.dma1) ? ~s.rxact
    : ~rne; // RULE3 RULE4 RULE17
  // Pass-through inverter; crystal drive is left to the pad
  assign osc_out = ~osc_in; // RULE8
  assign osc_out_en = ~s.irq_enable[FUD_IE_SLEEP]; // RULE8

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_TX_MARK: assert property ($fell(reset) |-> serial_out) // RULE1
    else $error("serial output not idle after reset");
  AST_RX_MODE0_ONLY: assert property ( // RULE3
    (!s.fen && rne) |-> !rx_dma_ready_n)
    else $error("non-FIFO receive request not mode 0");
  AST_TX_MODE0_CLR: assert property ( // RULE19
    (!(s.fen && s.dma1) && tx_push && s.tc == '0) |=> tx_dma_ready_n)
    else $error("mode 0 transmit request stayed after write");
  AST_TX_MODE1_FULL: assert property ( // RULE5
    (s.fen && s.dma1 && tx_push && !tx_pop && s.tc == FULL_CNT - 1'b1)
    |=> tx_dma_ready_n)
    else $error("mode 1 transmit request active when full");
  AST_STROBE_ANSWER: assert property ( // RULE6
    (avs_chipselect && !avs_read && !write_strobe_low_n && !s.ack)
    |=> !avs_waitrequest || !avs_chipselect || write_strobe_low_n)
    else $error("low write strobe not answered");
  AST_SLEEP_FLOAT: assert property ( // RULE8
    (wr_take && avs_address == FUD_REG_IRQ_ENABLE && !dlab &&
    avs_writedata[FUD_IE_SLEEP]) |=> !osc_out_en)
    else $error("oscillator output driven in sleep");
  AST_TX_START_LOW: assert property ( // RULE9
    (s.tph == PH_START) |-> !serial_out)
    else $error("start bit not low");
  AST_RX_NO_PARITY: assert property ( // RULE10
    (rx_push && !pen) |-> !rx_wdata[8])
    else $error("parity error without parity");
  AST_FIFO_LIMIT: assert property ( // RULE11 RULE16
    s.rc <= limit && s.tc <= limit)
    else $error("FIFO count above limit");
  AST_DIV_LOW: assert property ( // RULE15
    (wr_take && avs_address == FUD_REG_HOLDING && dlab) |-> !tx_push
    ##1 s.divisor[7:0] == $past(avs_writedata[7:0]))
    else $error("divisor low byte write misrouted");
  AST_RX_MODE1_IDLE: assert property ( // RULE17
    (s.fen && s.dma1 && s.rc == '0) |-> rx_dma_ready_n)
    else $error("mode 1 receive request while empty");
  AST_BAUD_TICK: assert property ( // RULE18
    (tick && s.divisor == 16'h0003 && $stable(s.divisor))
    |=> !tick ##1 !tick ##1 tick)
    else $error("baud tick spacing wrong");

  COV_TX_CHAR: cover property (tx_pop);
  COV_RX_CHAR: cover property (rx_push && s.fen);
  COV_RX_MODE1: cover property ($fell(rx_dma_ready_n) && s.dma1);
endmodule
`default_nettype wire

/* tb/fud_serial_peer.sv */
// Serial peer model that sends framed characters into the core
`default_nettype none
module fud_serial_peer #(
  parameter int BIT_CLKS = 16 // Clocks per bit at divisor 1
) (
  input wire logic clk_sys, // System clock
  output logic line // Serial line into the core
);
  timeunit 1ns;
  timeprecision 1ns;
  // Line rests at mark between characters, as a real peer would
  initial begin
    line = 1'b1;
  end
  // Start, eight data bits LSB first, even parity, one stop bit
  // A set bad flag inverts the parity bit to provoke a receive error
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

/* tb/test_fud_uart_core.sv */
// Self-checking bench for the FIFO UART core
`default_nettype none
module test_fud_uart_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_chipselect = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic write_strobe_high = 1'b0;
  logic write_strobe_low_n = 1'b1;
  logic serial_in, serial_out, tx_dma_ready_n, rx_dma_ready_n;
  logic osc_in = 1'b0;
  logic osc_out, osc_out_en;
  logic [7:0] q;
  logic [10:0] f;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // --------------------------------------------------------------------
  // Design, peer and clock
  // --------------------------------------------------------------------
  fud_uart_core fud_uart_core_inst (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_chipselect(avs_chipselect),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .write_strobe_high(write_strobe_high),
    .write_strobe_low_n(write_strobe_low_n), .serial_in(serial_in),
    .serial_out(serial_out), .tx_dma_ready_n(tx_dma_ready_n),
    .rx_dma_ready_n(rx_dma_ready_n), .osc_in(osc_in), .osc_out(osc_out),
    .osc_out_en(osc_out_en));
  fud_serial_peer fud_serial_peer_inst (.clk_sys(clk_sys), .line(serial_in));
  always #25 clk_sys = ~clk_sys;
  // Hang guard: the longest wait is a full transmit FIFO drain
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Mode 0 Avalon, 1 high strobe, 2 low strobe; strobes only write
  task automatic acc(input logic wr, input int md, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] rd);
    avs_chipselect <= 1'b1;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr && md == 0;
    write_strobe_high <= wr && md == 1;
    write_strobe_low_n <= !(wr && md == 2);
    // No assumed latency; only the hang guard ends this wait
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_chipselect <= 1'b0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    write_strobe_high <= 1'b0;
    write_strobe_low_n <= 1'b1;
    // Gap edge keeps a strobe from being driven twice in one step
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    acc(1'b1, 0, a, d, x);
  endtask
  // Frame capture from the falling start edge, sampled mid-bit
  task automatic grab(output logic [10:0] fr);
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      fr[i] = serial_out;
      repeat (16) @(posedge clk_sys);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("serial_out", serial_out, 1'b1);
    chk("tx_ready", tx_dma_ready_n, 1'b0);
    chk("rx_ready", rx_dma_ready_n, 1'b1);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      acc(1'b1, m, 3'h7, 8'h5a + m[7:0], q);
      acc(1'b0, 0, 3'h7, 8'h00, q);
      chk("scratch", q, 8'h5a + m[7:0]);
    end
    $display("test strobes done");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h03);
    acc(1'b0, 0, 3'h0, 8'h00, q);
    chk("divisor_low", q, 8'h03);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h1b);
    acc(1'b0, 0, 3'h1, 8'h00, q);
    chk("irq_enable", q, 8'h00);
    $display("test divisor done");
    osc_in <= 1'b1;
    @(posedge clk_sys);
    chk("osc_out", osc_out, 1'b0);
    wr(3'h1, 8'h10);
    chk("osc_out_en", osc_out_en, 1'b0);
    wr(3'h1, 8'h00);
    $display("test sleep done");
    fork
      grab(f);
      wr(3'h0, 8'h07);
    join
    chk("frame", f, {1'b1, 1'b1, 8'h07, 1'b0});
    $display("test frame done");
    // Divisor 2 makes the first frame outlast the fill: a single pop
    wr(3'h3, 8'h9b);
    wr(3'h0, 8'h02);
    wr(3'h3, 8'h1b);
    wr(3'h2, 8'h09);
    for (int i = 0; i < 64; i++) wr(3'h0, i[7:0]);
    chk("tx_ready_63", tx_dma_ready_n, 1'b0);
    wr(3'h0, 8'hff);
    chk("tx_ready_full", tx_dma_ready_n, 1'b1);
    wr(3'h2, 8'h01);
    chk("tx_ready_m0", tx_dma_ready_n, 1'b1);
    // Back to divisor 1 so the drain and the peer use 16 clocks a bit
    wr(3'h3, 8'h9b);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h1b);
    q = 8'h00;
    for (int i = 0; i < 6000 && q[6] !== 1'b1; i++) begin
      acc(1'b0, 0, 3'h5, 8'h00, q);
    end
    chk("tx_idle", q[6], 1'b1);
    chk("tx_ready_empty", tx_dma_ready_n, 1'b0);
    $display("test tx dma done");
    wr(3'h2, 8'hc8);
    fud_serial_peer_inst.send(8'h3c, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk("rx_ready_nofifo", rx_dma_ready_n, 1'b0);
    acc(1'b0, 0, 3'h0, 8'h00, q);
    chk("rx_data", q, 8'h3c);
    wr(3'h2, 8'h49);
    fud_serial_peer_inst.send(8'hc3, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk("rx_ready_trig", rx_dma_ready_n, 1'b1);
    acc(1'b0, 0, 3'h0, 8'h00, q);
    chk("rx_data", q, 8'hc3);
    fud_serial_peer_inst.send(8'h81, 1'b1);
    repeat (40) @(posedge clk_sys);
    acc(1'b0, 0, 3'h5, 8'h00, q);
    chk("parity_err", q[2], 1'b1);
    // Four character times of silence raise the mode 1 request
    repeat (700) @(posedge clk_sys);
    chk("rx_ready_tmo", rx_dma_ready_n, 1'b0);
    acc(1'b0, 0, 3'h0, 8'h00, q);
    chk("rx_err_data", q, 8'h81);
    chk("rx_empty", rx_dma_ready_n, 1'b1);
    $display("test rx done");
    complete_run();
  end
endmodule
`default_nettype wire
